// File: rtl/nvsc_pkg.sv
/*
 Shared constants and types for the nonvolatile SRAM host controller.
 Assumes a 200 MHz system clock; all pin timings are counted in cycles of it.
*/
package nvsc_pkg;

    localparam int CLK_PERIOD_PS = 5000;

    // Pin timing figures in their own units and the derived cycle counts.
    localparam int STORE_PULSE_NS = 15;
    localparam int STORE_PULSE_CYC = (STORE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BUSY_START_NS = 300;
    localparam int BUSY_START_CYC = (BUSY_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int INHIBIT_RELEASE_NS = 700;
    localparam int INHIBIT_RELEASE_CYC = (INHIBIT_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STORE_CYCLE_MS = 10;
    localparam int STORE_CYCLE_CYC = (STORE_CYCLE_MS * 1000000) / (CLK_PERIOD_PS / 1000);
    localparam int RECALL_US = 20;
    localparam int RECALL_CYC = (RECALL_US * 1000000) / CLK_PERIOD_PS;
    localparam int POWERUP_RECALL_US = 550;
    localparam int POWERUP_RECALL_CYC = (POWERUP_RECALL_US * 1000000) / CLK_PERIOD_PS;
    localparam int CYCLE_NS = 55;
    localparam int CYCLE_CYC = (CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ADDR_SETTLE_CYC = 1;
    localparam int SEQ_STEPS = 6;

    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CNT_W = 24;

    // Host command codes.
    localparam logic [2:0] CMD_READ = 3'h0;
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_HW_STORE = 3'h2;
    localparam logic [2:0] CMD_SW_SEQ = 3'h3;

    typedef struct packed {
        logic [2:0] cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } nvsc_req_t;

    // Memory pins as driven by the host; active-low strobes.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic chip_en_n;
        logic write_en_n;
        logic out_en_n;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
        logic hsb_out_n;
        logic hsb_oe;
    } nvsc_pins_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_SETUP = 4'h1,
        ST_STROBE = 4'h2,
        ST_HOLD = 4'h3,
        ST_HSB_PULSE = 4'h4,
        ST_HSB_WAIT_BUSY = 4'h5,
        ST_HSB_WAIT_DONE = 4'h6,
        ST_RECOVER = 4'h7,
        ST_NV_WAIT = 4'h8,
        ST_POWERUP = 4'h9
    } nvsc_state_t;

endpackage

// File: rtl/nvsc_timer.sv
/*
 Down-counting timer used for every wait of the controller.
 Assumes the load value fits the counter width.
*/
`timescale 1ns/1ps
module nvsc_timer #(
    parameter int W = 24
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic expired
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    // Loading wins over counting so back-to-back waits never merge.
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = value;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // Expiry looks at the count alone; gating it with load would close a loop through the caller's decode.
    assign expired = (count == '0);
endmodule

// File: rtl/nvsc_host.sv
/*
 Host controller driving an asynchronous nonvolatile SRAM through its pins.
 Assumes pin inputs are synchronous to clock and the bench resolves the
 shared data and store/busy wires from the output enables.
*/
// Summary of operation
// - The host holds the store/busy line high through every write cycle.
// - The host holds write-enable and store/busy high through every read cycle.
// - The host keeps chip-enable high whenever address lines change.
// - The host holds the store request line low for at least 15 ns.
// - The host performs six reads of the sequence addresses in order to start a software store or recall.
// - The host keeps write-enable high across all six sequence cycles.
`timescale 1ns/1ps
module nvsc_host
    import nvsc_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_RECALL_CYC,
    parameter int STORE_CYCLES = STORE_CYCLE_CYC,
    parameter int RECALL_CYCLES = RECALL_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic req_valid,
    input wire nvsc_pkg::nvsc_req_t req,
    input wire logic [nvsc_pkg::ADDR_W-1:0] seq_addr [nvsc_pkg::SEQ_STEPS],
    input wire logic seq_is_store,
    output logic req_ready,
    output logic rsp_valid,
    output logic [nvsc_pkg::DATA_W-1:0] rsp_rdata,
    output logic rsp_timeout,
    output nvsc_pkg::nvsc_pins_t pins,
    input wire logic [nvsc_pkg::DATA_W-1:0] dq_in,
    input wire logic hsb_in_n
);
    import nvsc_pkg::*;

    nvsc_state_t state;
    nvsc_state_t next_state;
    nvsc_req_t cur;
    nvsc_req_t next_cur;
    nvsc_pins_t next_pins;
    logic [2:0] step;
    logic [2:0] next_step;
    logic next_req_ready;
    logic next_rsp_valid;
    logic [DATA_W-1:0] next_rsp_rdata;
    logic next_rsp_timeout;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_value;
    logic tmr_expired;
    logic pu_loaded;

    // One timer serves every wait; the state machine reloads it on each entry.
    nvsc_timer #(.W(CNT_W)) u_timer (
        .clock(clock),
        .srst(srst),
        .load(tmr_load),
        .value(tmr_value),
        .expired(tmr_expired)
    );

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction

    // Sequencer for accesses, hardware store and software sequence.
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_pins = pins;
        next_step = step;
        next_req_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        next_rsp_timeout = 1'b0;
        tmr_load = 1'b0;
        tmr_value = '0;
        case (state)
            ST_POWERUP: begin
                // Nothing may touch the part until its power-up recall has surely finished.
                if (!pu_loaded) begin
                    tmr_load = 1'b1;
                    tmr_value = cyc(POWERUP_CYCLES);
                end else if (tmr_expired) begin
                    next_state = ST_IDLE;
                    next_req_ready = 1'b1;
                end
            end
            ST_IDLE: begin
                next_req_ready = 1'b1;
                if (req_valid && req_ready) begin
                    next_req_ready = 1'b0;
                    next_cur = req;
                    next_step = '0;
                    next_pins.hsb_oe = 1'b0; // Store line left high by its pull-up.
                    if (req.cmd == CMD_HW_STORE) begin
                        next_pins.hsb_out_n = 1'b0;
                        next_pins.hsb_oe = 1'b1;
                        tmr_load = 1'b1;
                        tmr_value = cyc(STORE_PULSE_CYC);
                        next_state = ST_HSB_PULSE;
                    end else begin
                        // Address changes only while chip-enable is high.
                        next_pins.addr = (req.cmd == CMD_SW_SEQ) ? seq_addr[0] : req.addr;
                        tmr_load = 1'b1;
                        tmr_value = cyc(ADDR_SETTLE_CYC);
                        next_state = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                if (tmr_expired) begin
                    next_pins.chip_en_n = 1'b0;
                    if (cur.cmd == CMD_WRITE) begin
                        // Write-enable goes low with chip-enable so outputs stay floating.
                        next_pins.write_en_n = 1'b0;
                        next_pins.dq_out = cur.wdata;
                        next_pins.dq_oe = 1'b1;
                    end else begin
                        next_pins.write_en_n = 1'b1;
                        next_pins.out_en_n = 1'b0;
                    end
                    tmr_load = 1'b1;
                    tmr_value = cyc(CYCLE_CYC);
                    next_state = ST_STROBE;
                end
            end
            ST_STROBE: begin
                // One falling chip-enable per step; the strobe ends before the next address.
                if (tmr_expired) begin
                    next_pins.chip_en_n = 1'b1;
                    next_pins.write_en_n = 1'b1;
                    next_pins.out_en_n = 1'b1;
                    next_rsp_rdata = dq_in;
                    tmr_load = 1'b1;
                    tmr_value = cyc(ADDR_SETTLE_CYC);
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (tmr_expired) begin
                    next_pins.dq_oe = 1'b0;
                    if (cur.cmd == CMD_SW_SEQ && step != 3'(SEQ_STEPS - 1)) begin
                        // Next sequence address, strictly in order.
                        next_step = step + 3'h1;
                        next_pins.addr = seq_addr[step + 3'h1];
                        tmr_load = 1'b1;
                        tmr_value = cyc(ADDR_SETTLE_CYC);
                        next_state = ST_SETUP;
                    end else if (cur.cmd == CMD_SW_SEQ) begin
                        tmr_load = 1'b1;
                        tmr_value = seq_is_store ? cyc(STORE_CYCLES) : cyc(RECALL_CYCLES);
                        next_state = ST_NV_WAIT;
                    end else begin
                        next_rsp_valid = 1'b1;
                        next_req_ready = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_HSB_PULSE: begin
                if (tmr_expired) begin
                    next_pins.hsb_oe = 1'b0;
                    next_pins.hsb_out_n = 1'b1;
                    tmr_load = 1'b1;
                    tmr_value = cyc(BUSY_START_CYC);
                    next_state = ST_HSB_WAIT_BUSY;
                end
            end
            ST_HSB_WAIT_BUSY: begin
                // Busy may take up to its start time; a store skipped for lack of writes never shows it.
                if (!hsb_in_n) begin
                    tmr_load = 1'b1;
                    tmr_value = cyc(STORE_CYCLES);
                    next_state = ST_HSB_WAIT_DONE;
                end else if (tmr_expired) begin
                    tmr_load = 1'b1;
                    tmr_value = cyc(INHIBIT_RELEASE_CYC);
                    next_state = ST_RECOVER;
                end
            end
            ST_HSB_WAIT_DONE: begin
                // Inhibit lifts only after busy ends, then the release time runs.
                if (hsb_in_n) begin
                    tmr_load = 1'b1;
                    tmr_value = cyc(INHIBIT_RELEASE_CYC);
                    next_state = ST_RECOVER;
                end else if (tmr_expired) begin
                    next_rsp_timeout = 1'b1;
                    next_rsp_valid = 1'b1;
                    next_req_ready = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_RECOVER, ST_NV_WAIT: begin
                // Accesses are held back until the part has finished.
                if (tmr_expired) begin
                    next_rsp_valid = 1'b1;
                    next_req_ready = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // A store driven by the part itself stalls new work.
        if (state == ST_IDLE && !hsb_in_n && !pins.hsb_oe) begin
            next_req_ready = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state <= ST_POWERUP;
            cur <= '0;
            step <= '0;
            pins <= '{addr: '0, chip_en_n: 1'b1, write_en_n: 1'b1, out_en_n: 1'b1,
                      dq_out: '0, dq_oe: 1'b0, hsb_out_n: 1'b1, hsb_oe: 1'b0};
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_timeout <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            step <= next_step;
            pins <= next_pins;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
            rsp_timeout <= next_rsp_timeout;
        end
    end

    // Marks the first cycle after reset, in which the power-up wait is loaded into the timer.
    always_ff @(posedge clock) begin
        if (srst) begin
            pu_loaded <= 1'b0;
        end else begin
            pu_loaded <= 1'b1;
        end
    end
    a_hsb_write_high: assert property (@(posedge clock) disable iff (srst)
        !pins.write_en_n |-> !(pins.hsb_oe && !pins.hsb_out_n))
        else $error("store line driven low during write");
    a_read_we_high: assert property (@(posedge clock) disable iff (srst)
        !pins.out_en_n |-> pins.write_en_n && !pins.hsb_oe)
        else $error("write-enable or store low during read");
    a_addr_stable_ce: assert property (@(posedge clock) disable iff (srst)
        !$stable(pins.addr) |-> pins.chip_en_n && $past(pins.chip_en_n))
        else $error("address changed with chip enabled");
    sequence s_hsb_fall;
        !$past(pins.hsb_oe) && pins.hsb_oe && !pins.hsb_out_n;
    endsequence
    a_hsb_pulse_width: assert property (@(posedge clock) disable iff (srst)
        s_hsb_fall |-> (pins.hsb_oe && !pins.hsb_out_n)[*3])
        else $error("store pulse too short");
    a_seq_we_high: assert property (@(posedge clock) disable iff (srst)
        (cur.cmd == CMD_SW_SEQ && state == ST_STROBE) |-> pins.write_en_n)
        else $error("write-enable low in sequence");
    a_seq_order: assert property (@(posedge clock) disable iff (srst)
        (cur.cmd == CMD_SW_SEQ && state == ST_STROBE) |-> pins.addr == seq_addr[step])
        else $error("sequence address out of order");
    a_write_we_first: assert property (@(posedge clock) disable iff (srst)
        ($fell(pins.chip_en_n) && cur.cmd == CMD_WRITE) |-> !pins.write_en_n && !pins.out_en_n == 1'b0)
        else $error("write strobe not with chip enable");
    a_single_strobe: assert property (@(posedge clock) disable iff (srst)
        $fell(pins.chip_en_n) |=> !pins.chip_en_n[*8])
        else $error("chip enable strobe too short");
    a_no_access_busy: assert property (@(posedge clock) disable iff (srst)
        (state == ST_HSB_WAIT_DONE || state == ST_NV_WAIT || state == ST_POWERUP) |-> pins.chip_en_n)
        else $error("access during nonvolatile cycle");
endmodule

// File: testbench/nvsc_mem_model.sv
/*
 Behavioural model of the nonvolatile SRAM as seen at its pins.
 Assumes pins are registered on clock and that the bench resolves dq and store/busy.
*/
`timescale 1ns/1ps
module nvsc_mem_model
    import nvsc_pkg::*;
#(
    parameter int STORE_LEN = 100,
    parameter int INH_LEN = 60,
    parameter int RECALL_LEN = 40,
    parameter int PF_LEN = 200,
    parameter logic [12:0] STORE_LAST = 13'h1f00,
    parameter logic [12:0] RECALL_LAST = 13'h00f1
) (
    input wire logic clock,
    input wire logic srst,
    input wire nvsc_pkg::nvsc_pins_t pins,
    input wire logic [7:0] dq_in,
    input wire logic [12:0] seq_addr [6],
    input wire logic slow,
    input wire logic supply_drop,
    output logic [7:0] mdq,
    output logic mdq_oe,
    output logic hsb_low
);
    logic [7:0] sram [8192];
    logic [7:0] nv [8192];
    logic prev_ce = 1'b1;
    logic prev_we = 1'b1;
    int pf_cnt = 0;
    logic floating = 1'b0;
    logic dirty = 1'b0;
    int busy_cnt = 0;
    int inh_cnt = 0;
    int req_cnt = 0;
    int step = 0;
    int n_store = 0;
    int n_skip = 0;
    int n_recall = 0;
    logic inactive;

    // Accesses are ignored while busy or inhibited.
    assign inactive = (busy_cnt != 0) || (inh_cnt != 0);
    assign hsb_low = (busy_cnt != 0) || (pf_cnt != 0);
    assign mdq = sram[pins.addr];
    assign mdq_oe = !pins.chip_en_n && !pins.out_en_n && pins.write_en_n && !floating && !inactive;

    // A store with nothing written since the last one is skipped and busy is released.
    task automatic begin_store();
        if (dirty) begin
            nv = sram;
            dirty <= 1'b0;
            busy_cnt <= STORE_LEN;
            n_store++;
        end else begin
            n_skip++;
        end
    endtask

    // Memory behaviour; the reset stands for power-up, whose recall ends within it.
    always @(posedge clock) begin
        prev_ce <= pins.chip_en_n;
        prev_we <= pins.write_en_n;
        if (srst) begin
            sram = nv;
            busy_cnt <= 0;
            pf_cnt <= 0;
            inh_cnt <= 0;
            req_cnt <= 0;
            step <= 0;
            floating <= 1'b0;
        end else begin
            // Inhibit is lifted a bounded time after busy ends.
            if (busy_cnt != 0) begin
                busy_cnt <= busy_cnt - 1;
                if (busy_cnt == 1) inh_cnt <= INH_LEN;
            end else if (inh_cnt != 0) begin
                inh_cnt <= inh_cnt - 1;
            end
            // Supply loss holds the store line low for its pulse, then stores only if written.
            if (supply_drop && pf_cnt == 0 && busy_cnt == 0) begin
                pf_cnt <= PF_LEN;
            end else if (pf_cnt == 1) begin
                pf_cnt <= 0;
                begin_store();
            end else if (pf_cnt > 1) begin
                pf_cnt <= pf_cnt - 1;
            end
            if (busy_cnt == 0 && req_cnt == 0 && pins.hsb_oe && !pins.hsb_out_n) begin
                req_cnt <= slow ? 40 : 4;
            end
            // A cycle in progress is let finish before the store starts.
            if (req_cnt == 1 && pins.chip_en_n) begin
                req_cnt <= 0;
                begin_store();
            end else if (req_cnt > 1) begin
                req_cnt <= req_cnt - 1;
            end
            // The sequence steps on chip-enable falls only; a wrong step restarts it.
            if (prev_ce && !pins.chip_en_n && !inactive) begin
                floating <= !pins.write_en_n;
                if (pins.write_en_n) begin
                    if (step == 5 && pins.addr == STORE_LAST) begin
                        step <= 0;
                        begin_store();
                    end else if (step == 5 && pins.addr == RECALL_LAST) begin
                        step <= 0;
                        sram = nv;
                        inh_cnt <= RECALL_LEN;
                        n_recall++;
                    end else if (step < 5 && pins.addr == seq_addr[step]) begin
                        step <= step + 1;
                    end else begin
                        step <= (pins.addr == seq_addr[0]) ? 1 : 0;
                    end
                end
            end
            if (!prev_ce && pins.chip_en_n) begin
                floating <= 1'b0;
                // Write-enable may rise with chip-enable, so the strobe level before the edge decides.
                if (!prev_we && !inactive) begin
                    sram[pins.addr] = dq_in;
                    dirty <= 1'b1;
                    step <= 0;
                end
            end
        end
    end
endmodule

// File: testbench/nv_sram_store_recall_control_tb.sv
/*
 Self-checking bench for the nonvolatile SRAM host controller.
 Assumes the memory model beside it and shortened wait parameters.
*/
`timescale 1ns/1ps
module nv_sram_store_recall_control_tb;
    import nvsc_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    nvsc_req_t req = '0;
    logic [12:0] seq_addr [6];
    logic seq_is_store = 1'b0;
    logic req_ready, rsp_valid, rsp_timeout, hsb_in_n, mdq_oe, hsb_low, slow = 1'b0;
    logic supply_drop = 1'b0;
    logic [7:0] rsp_rdata, dq_in, mdq, last_dq = 8'h00, got;
    nvsc_pins_t pins;
    logic [12:0] prev_addr = 13'h0000;
    logic prev_ce = 1'b1;
    int n_mismatch = 0;
    int n_compared = 0;

    nvsc_host #(.POWERUP_CYCLES(50), .STORE_CYCLES(300), .RECALL_CYCLES(50)) dut (.clock(clock), .srst(srst),
        .req_valid(req_valid), .req(req), .seq_addr(seq_addr), .seq_is_store(seq_is_store), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout), .pins(pins), .dq_in(dq_in),
        .hsb_in_n(hsb_in_n));
    nvsc_mem_model mem (.clock(clock), .srst(srst), .pins(pins), .dq_in(dq_in), .seq_addr(seq_addr), .slow(slow),
        .supply_drop(supply_drop), .mdq(mdq), .mdq_oe(mdq_oe), .hsb_low(hsb_low));

    // Undriven data shows the inverse of its last value; store/busy has a pull-up.
    assign dq_in = pins.dq_oe ? pins.dq_out : (mdq_oe ? mdq : ~last_dq);
    assign hsb_in_n = !((pins.hsb_oe && !pins.hsb_out_n) || hsb_low);

    initial begin
        forever #2.5 clock = ~clock;
    end

    // Bus watch: address steady and store line untouched while chip-enable is low.
    always @(posedge clock) begin
        last_dq <= dq_in;
        prev_ce <= pins.chip_en_n;
        prev_addr <= pins.addr;
        if (!srst && !prev_ce && !pins.chip_en_n && pins.addr !== prev_addr) begin
            n_mismatch++;
            $display("Error at %0t: address moved %h to %h", $time, prev_addr, pins.addr);
        end
        if (!srst && !pins.chip_en_n && pins.hsb_oe !== 1'b0) begin
            n_mismatch++;
            $display("Error at %0t: store line driven in cycle %h expected %h", $time, pins.hsb_oe, 1'b0);
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // One request through the handshake; read data is kept in got.
    task automatic do_req(input logic [2:0] c, input logic [12:0] a, input logic [7:0] d);
        int k;
        @(negedge clock);
        req_valid = 1'b1;
        req = '{cmd: c, addr: a, wdata: d};
        k = 0;
        while (req_ready !== 1'b1 && k < 5000) begin
            @(negedge clock);
            k++;
        end
        @(negedge clock);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && k < 5000) begin
            @(negedge clock);
            k++;
        end
        chk(k < 5000, 1);
        chk(rsp_timeout, 1'b0);
        got = rsp_rdata;
    endtask

    task automatic t_reset();
        int k;
        chk({pins.chip_en_n, pins.write_en_n, pins.out_en_n, pins.dq_oe, pins.hsb_oe}, 5'h1c);
        k = 0;
        while (req_ready !== 1'b1 && k < 200) begin
            @(negedge clock);
            k++;
        end
        chk(k < 200, 1);
        chk(k >= 50, 1);
        $display("test reset done");
    endtask

    // Boundary and alternating-bit addresses written and read back; outputs float during writes.
    task automatic t_rw();
        logic [12:0] a [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
        for (int i = 0; i < 4; i++) do_req(CMD_WRITE, a[i], 8'h3c + 8'(i));
        for (int i = 0; i < 4; i++) begin
            do_req(CMD_READ, a[i], 8'h00);
            chk(got, 8'h3c + 8'(i));
        end
        $display("test read write done");
    endtask

    // Hardware store: prompt or slow busy, then a skipped store with nothing written.
    task automatic t_hw_store(input logic s);
        int n0, k0;
        slow = s;
        n0 = mem.n_store;
        k0 = mem.n_skip;
        do_req(CMD_WRITE, 13'h0042, 8'h99);
        do_req(CMD_HW_STORE, 13'h0000, 8'h00);
        chk(mem.n_store, n0 + 1);
        do_req(CMD_HW_STORE, 13'h0000, 8'h00);
        chk(mem.n_skip, k0 + 1);
        do_req(CMD_READ, 13'h0042, 8'h00);
        chk(got, 8'h99);
        $display("test hardware store done");
    endtask

    // Software store, overwrite, software recall, then the stored byte must return.
    task automatic t_sw_seq();
        int n0, r0;
        n0 = mem.n_store;
        r0 = mem.n_recall;
        do_req(CMD_WRITE, 13'h0123, 8'h5a);
        seq_addr[5] = mem.STORE_LAST;
        seq_is_store = 1'b1;
        do_req(CMD_SW_SEQ, 13'h0000, 8'h00);
        chk(mem.n_store, n0 + 1);
        do_req(CMD_WRITE, 13'h0123, 8'ha5);
        seq_addr[5] = mem.RECALL_LAST;
        seq_is_store = 1'b0;
        do_req(CMD_SW_SEQ, 13'h0000, 8'h00);
        chk(mem.n_recall, r0 + 1);
        do_req(CMD_READ, 13'h0123, 8'h00);
        chk(got, 8'h5a);
        $display("test software sequence done");
    endtask

    // Supply loss twice: first with a written array, which stores, then clean, which skips.
    task automatic t_supply_loss();
        int n0, k0, k;
        do_req(CMD_WRITE, 13'h0077, 8'h6e);
        n0 = mem.n_store;
        k0 = mem.n_skip;
        for (int i = 0; i < 2; i++) begin
            @(negedge clock);
            supply_drop = 1'b1;
            @(negedge clock);
            supply_drop = 1'b0;
            repeat (4) @(negedge clock);
            chk({hsb_in_n, req_ready}, 2'b00);
            k = 0;
            while (req_ready !== 1'b1 && k < 1000) begin
                @(negedge clock);
                k++;
            end
            chk(k >= 190 && k < 1000, 1);
            repeat (100) @(negedge clock);
        end
        chk(mem.n_store, n0 + 1);
        chk(mem.n_skip, k0 + 1);
        do_req(CMD_READ, 13'h0077, 8'h00);
        chk(got, 8'h6e);
        $display("test supply loss done");
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog reckoned from a few thousand cycles of expected traffic.
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        finish_test();
    end

    initial begin
        seq_addr = '{13'h0101, 13'h0202, 13'h0404, 13'h0808, 13'h1010, 13'h1f00};
        repeat (12) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        t_reset();
        t_rw();
        t_hw_store(1'b0);
        t_hw_store(1'b1);
        t_sw_seq();
        t_supply_loss();
        finish_test();
    end
endmodule
